// >>> hdl/ssp_page_builder.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - page bytes 0 and 1 carry revision 0010h, low byte first
// RL2 - bytes 2 to 361 hold thirty twelve-byte attribute records
// RL3 - read request: busy, fill buffer, then data request, drop busy, interrupt
// RL4 - a record with identifier zero is an unused slot
// RL5 - crc error count attribute 199 starts its value at c8h
// RL6 - identifiers follow the fixed table, e.g. 9, 194, 198
// RL7 - byte 362: 00h/80h never ran, 03h/83h running
// RL8 - byte 362: 02h/82h done cleanly; reserved codes never produced
// RL9 - byte 362: 04h/84h host suspended, 05h/85h host aborted
// RL10 - byte 362: 06h/86h device abandoned on fatal error
// RL11 - byte 363 low nibble: remaining self-test in tenths, 0 to 9
// RL12 - result code 0 pass, 1 host abort, 2 reset interrupted
// RL13 - result code 3 on fatal or unknown self-test error
// RL14 - result codes 4 to 7 name the failing element
// RL15 - result code 15 while self-test runs
// RL16 - bytes 364 and 365 give collection time in seconds
// RL17 - byte 367 bits 0 and 1 always one
// RL18 - byte 367 bit 2 set: abort on host command, clear: suspend
// RL19 - byte 367 bits 3, 4, 6 one; bits 5, 7 zero
// RL20 - bytes 368-369: bits 0 and 1 one, rest zero
// RL21 - byte 371 keeps checkpoint of the last failed self-test
// RL22 - host should wait the polling minutes before first status poll
// RL23 - early polling extends or aborts the self-test, per bit 2
// RL24 - byte 511 is a checksum over bytes 0 to 510
// RL25 - all 512 bytes sum to zero; reserved bytes read zero
module ssp_page_builder #(
  parameter logic [7:0] POLL_SHORT = 8'h02,
  parameter logic [7:0] POLL_EXT   = 8'h1e
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // host events
  input  wire logic        pageReq,
  input  wire logic        rdStrobe,
  input  wire logic        hostCmd,
  input  wire logic        hostReset,
  // page handshake and data
  output logic             busy,
  output logic             dataReq,
  output logic             intReq,
  output logic [7:0]       rdData,
  // attribute records
  input  wire logic        attrWrEn,
  input  wire logic [8:0]  attrWrAddr,
  input  wire logic [7:0]  attrWrData,
  output logic             attrWrRejected,
  // background collection
  input  wire logic        autoCollEn,
  input  wire logic        abortOnCmd,
  input  wire logic        collStart,
  input  wire logic        collResume,
  input  wire logic        collDone,
  input  wire logic        collFatal,
  input  wire logic [15:0] collTimeSec,
  // self-test engine
  input  wire logic        stStart,
  input  wire logic [3:0]  stPct,
  input  wire logic        stPass,
  input  wire logic        stFail,
  input  wire logic [1:0]  stFailElem,
  input  wire logic [7:0]  stFailChk,
  input  wire logic        stFatal,
  input  wire logic        stAbortCmd,
  output logic             testExtend,
  output logic             testAbort
);
  import ssp_pkg::*;
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ssp_state_t  stateReg;
  logic [8:0]  idxReg;
  logic [8:0]  rdCnt;
  logic [7:0]  sumReg;
  logic [7:0]  pageBuf [PAGE_BYTES];
  logic [7:0]  fillByte;
  logic [7:0]  attrByte;
  logic [2:0]  collCode;
  logic [3:0]  testCode;
  logic [3:0]  testPct;
  logic [7:0]  failChk;
  logic        take;
  logic        hostCmdAny;
  logic        testRun;
  logic [9:0]  busyLen;

  assign take       = pageReq && stateReg == SSP_IDLE;
  // the page read itself is a host command for collection purposes
  assign hostCmdAny = hostCmd || take;
  assign testRun    = testCode == TEST_RUN;

  ssp_attr_store ssp_attr_store_inst (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wrEn       (attrWrEn),
    .wrAddr     (attrWrAddr),
    .wrData     (attrWrData),
    .wrRejected (attrWrRejected),
    .rdAddr     (9'(idxReg - OFF_ATTR)),
    .rdData     (attrByte)
  );

  always_comb
  begin
    fillByte = 8'h00; // RL25
    if (idxReg >= OFF_ATTR && idxReg <= OFF_ATTR_END)
      fillByte = attrByte; // RL2
    else
    begin
      case (idxReg)
        OFF_REV_LO:  fillByte = PAGE_REV[7:0]; // RL1
        OFF_REV_HI:  fillByte = PAGE_REV[15:8]; // RL1
        OFF_COLL:    fillByte = {autoCollEn, 4'h0, collCode}; // RL7
        OFF_TEST:    fillByte = {testCode, testPct}; // RL11
        OFF_TIME_LO: fillByte = collTimeSec[7:0]; // RL16
        OFF_TIME_HI: fillByte = collTimeSec[15:8]; // RL16
        OFF_CAP:     fillByte = CAP_FIXED
                       | (8'(abortOnCmd) << CAP_ABORT_BIT); // RL17 RL19
        OFF_SCAP_LO: fillByte = SMART_CAP[7:0]; // RL20
        OFF_SCAP_HI: fillByte = SMART_CAP[15:8]; // RL20
        OFF_ERRLOG:  fillByte = ERRLOG_CAP;
        OFF_CHKPT:   fillByte = failChk; // RL21
        OFF_POLL_S:  fillByte = POLL_SHORT; // RL22
        OFF_POLL_E:  fillByte = POLL_EXT; // RL22
        OFF_SUM:     fillByte = 8'h00 - sumReg; // RL24 RL25
        default:     fillByte = 8'h00;
      endcase
    end
  end

  // page sequencer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= SSP_IDLE;
      idxReg   <= 9'h000;
      sumReg   <= 8'h00;
      rdCnt    <= 9'h000;
      busy     <= 1'b0;
      dataReq  <= 1'b0;
      intReq   <= 1'b0;
    end
    else
    begin
      intReq <= 1'b0;
      case (stateReg)
        SSP_IDLE:
        begin
          if (pageReq)
          begin
            stateReg <= SSP_FILL;
            idxReg   <= 9'h000;
            sumReg   <= 8'h00;
            busy     <= 1'b1; // RL3
          end
        end
        SSP_FILL:
        begin
          sumReg <= sumReg + fillByte; // RL24
          idxReg <= 9'(idxReg + 9'h001);
          if (idxReg == OFF_SUM)
          begin
            stateReg <= SSP_READY;
            busy     <= 1'b0; // RL3
            dataReq  <= 1'b1;
            intReq   <= 1'b1;
            rdCnt    <= 9'h000;
          end
        end
        SSP_READY:
        begin
          // further requests are ignored until the host has drained the page
          if (rdStrobe)
          begin
            rdCnt <= 9'(rdCnt + 9'h001);
            if (rdCnt == 9'(PAGE_BYTES - 1))
            begin
              stateReg <= SSP_IDLE;
              dataReq  <= 1'b0;
            end
          end
        end
        default: stateReg <= SSP_IDLE;
      endcase
    end
  end

  // the buffer holds a snapshot, so later status changes cannot break
  // the checksum of a page already built
  always_ff @(posedge ref_clk)
  begin
    if (stateReg == SSP_FILL)
      pageBuf[idxReg] <= fillByte; // RL3
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= 8'h00;
    else if (stateReg == SSP_READY && rdStrobe)
      rdData <= pageBuf[rdCnt];
  end

  // background collection status
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      collCode <= COLL_NEVER; // RL7
    else if (collFatal && collCode == COLL_RUN)
      collCode <= COLL_FATAL; // RL10
    else if (hostCmdAny && collCode == COLL_RUN)
      collCode <= abortOnCmd ? COLL_HABRT : COLL_SUSP; // RL9 RL18
    else if (collDone && collCode == COLL_RUN)
      collCode <= COLL_DONE; // RL8
    else if (collStart)
      collCode <= COLL_RUN; // RL7
    else if (collResume && collCode == COLL_SUSP)
      collCode <= COLL_RUN; // RL18
  end

  // self-test status
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      testCode   <= TEST_PASS;
      testPct    <= 4'h0;
      failChk    <= 8'h00;
      testExtend <= 1'b0;
      testAbort  <= 1'b0;
    end
    else
    begin
      testExtend <= 1'b0;
      testAbort  <= 1'b0;
      if (testRun)
      begin
        if (hostReset)
          testCode <= TEST_RESET; // RL12
        else if (stAbortCmd)
          testCode <= TEST_HABRT; // RL12
        else if (take && abortOnCmd)
        begin
          testCode  <= TEST_HABRT; // RL23
          testAbort <= 1'b1;
        end
        else if (stFatal)
        begin
          testCode <= TEST_FATAL; // RL13
          failChk  <= stFailChk; // RL21
        end
        else if (stFail)
        begin
          testCode <= 4'(TEST_FAIL + {2'b00, stFailElem}); // RL14
          failChk  <= stFailChk; // RL21
        end
        else if (stPass)
        begin
          testCode <= TEST_PASS; // RL12
          testPct  <= 4'h0; // RL11
        end
        else
        begin
          // early poll without abort just stretches the test
          testExtend <= take; // RL23
          if (stPct <= PCT_MAX)
            testPct <= stPct; // RL11
        end
      end
      else if (stStart)
      begin
        testCode <= TEST_RUN; // RL15
        testPct  <= PCT_MAX;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      busyLen <= 10'h000;
    else
      busyLen <= busy ? 10'(busyLen + 10'h001) : 10'h000;
  end

  AST_REV_LOW: assert property ( // RL1
    stateReg == SSP_FILL && idxReg == 9'h000 |-> fillByte == 8'h10)
    else $error("revision low byte wrong");

  AST_FILL_SEQ: assert property ( // RL3
    take |=> busy && !dataReq ##1 busy[*8])
    else $error("busy not held after request");

  AST_DRQ_RISE: assert property ( // RL3
    $rose(dataReq) |-> !busy && intReq && busyLen == 10'd512)
    else $error("data request timing wrong");

  AST_COLL_LEGAL: assert property ( // RL8
    collCode != 3'h1 && collCode != 3'h7)
    else $error("reserved collection code");

  AST_COLL_HOST: assert property ( // RL9
    collCode == COLL_RUN && hostCmd && !collFatal |=>
      collCode == ($past(abortOnCmd) ? 3'h5 : 3'h4))
    else $error("host command handling of collection wrong");

  AST_COLL_FATAL: assert property ( // RL10
    collCode == COLL_RUN && collFatal |=> collCode == 3'h6)
    else $error("fatal collection code missing");

  AST_PCT_RANGE: assert property ( // RL11
    testPct <= 4'h9)
    else $error("percent remaining out of range");

  AST_TEST_RUN: assert property ( // RL15
    !testRun && stStart |=> testCode == 4'hf && testPct == 4'h9)
    else $error("running code not shown");

  AST_FAIL_ELEM: assert property ( // RL14 RL21
    testRun && stFail && !hostReset && !stAbortCmd && !take && !stFatal
      |=> testCode == 4'h4 + $past(stFailElem)
      && failChk == $past(stFailChk))
    else $error("failing element code wrong");

  AST_CAP_BYTE: assert property ( // RL17 RL18 RL19
    stateReg == SSP_FILL && idxReg == OFF_CAP |->
      fillByte[7:3] == 5'h0b && fillByte[1:0] == 2'h3
      && fillByte[2] == abortOnCmd)
    else $error("capability byte wrong");

  // the running sum over all 512 bytes, checksum included, must cancel
  AST_SUM_ZERO: assert property ( // RL25
    $rose(dataReq) |-> sumReg == 8'h00)
    else $error("page checksum does not cancel");

  COV_PAGE_DONE: cover property (@(posedge ref_clk) disable iff (!rst_n)
    dataReq && rdStrobe && rdCnt == 9'h1ff);
  COV_SUSPEND: cover property (@(posedge ref_clk) disable iff (!rst_n)
    collCode == COLL_RUN ##1 collCode == COLL_SUSP);
  COV_TEST_FAIL: cover property (@(posedge ref_clk) disable iff (!rst_n)
    testRun ##1 testCode == 4'h6);
  COV_EXTEND: cover property (@(posedge ref_clk) disable iff (!rst_n)
    testExtend);
endmodule : ssp_page_builder

// >>> pkg/ssp_pkg.sv
package ssp_pkg;
  // page layout
  localparam int         PAGE_BYTES  = 512;
  localparam int         ATTR_SLOTS  = 30;
  localparam int         REC_BYTES   = 12;
  localparam logic [8:0] OFF_REV_LO  = 9'h000;
  localparam logic [8:0] OFF_REV_HI  = 9'h001;
  localparam logic [8:0] OFF_ATTR    = 9'h002;
  localparam logic [8:0] OFF_ATTR_END = 9'h169;
  localparam logic [8:0] OFF_COLL    = 9'h16a;
  localparam logic [8:0] OFF_TEST    = 9'h16b;
  localparam logic [8:0] OFF_TIME_LO = 9'h16c;
  localparam logic [8:0] OFF_TIME_HI = 9'h16d;
  localparam logic [8:0] OFF_CAP     = 9'h16f;
  localparam logic [8:0] OFF_SCAP_LO = 9'h170;
  localparam logic [8:0] OFF_SCAP_HI = 9'h171;
  localparam logic [8:0] OFF_ERRLOG  = 9'h172;
  localparam logic [8:0] OFF_CHKPT   = 9'h173;
  localparam logic [8:0] OFF_POLL_S  = 9'h174;
  localparam logic [8:0] OFF_POLL_E  = 9'h175;
  localparam logic [8:0] OFF_SUM     = 9'h1ff;
  // fixed contents
  localparam logic [15:0] PAGE_REV   = 16'h0010;
  localparam logic [7:0]  CAP_FIXED  = 8'h5b;
  localparam int          CAP_ABORT_BIT = 2;
  localparam logic [15:0] SMART_CAP  = 16'h0003;
  localparam logic [7:0]  ERRLOG_CAP = 8'h01;
  // attribute record
  localparam logic [3:0] REC_ID    = 4'h0;
  localparam logic [3:0] REC_VAL   = 4'h3;
  localparam logic [3:0] REC_WORST = 4'h4;
  localparam logic [7:0] VAL_INIT  = 8'h64;
  localparam logic [7:0] VAL_CRC   = 8'hc8;
  localparam logic [7:0] ATTR_ID_HOURS = 8'h09;
  localparam logic [7:0] ATTR_ID_TEMP  = 8'hc2;
  localparam logic [7:0] ATTR_ID_SCAN  = 8'hc6;
  localparam logic [7:0] ATTR_ID_CRC   = 8'hc7;
  localparam int         ID_COUNT = 23;
  localparam logic [7:0] ATTR_IDS [ID_COUNT] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, ATTR_ID_HOURS,
    8'h0a, 8'h0c, 8'hc0, 8'hc1, ATTR_ID_TEMP, 8'hc4, 8'hc5,
    ATTR_ID_SCAN, ATTR_ID_CRC, 8'hdc, 8'hde, 8'hdf, 8'he0, 8'he2,
    8'hf0};
  // background collection codes
  localparam logic [2:0] COLL_NEVER = 3'h0;
  localparam logic [2:0] COLL_DONE  = 3'h2;
  localparam logic [2:0] COLL_RUN   = 3'h3;
  localparam logic [2:0] COLL_SUSP  = 3'h4;
  localparam logic [2:0] COLL_HABRT = 3'h5;
  localparam logic [2:0] COLL_FATAL = 3'h6;
  // self-test codes
  localparam logic [3:0] TEST_PASS  = 4'h0;
  localparam logic [3:0] TEST_HABRT = 4'h1;
  localparam logic [3:0] TEST_RESET = 4'h2;
  localparam logic [3:0] TEST_FATAL = 4'h3;
  localparam logic [3:0] TEST_FAIL  = 4'h4;
  localparam logic [3:0] TEST_RUN   = 4'hf;
  localparam logic [3:0] PCT_MAX    = 4'h9;
  typedef enum logic [2:0] {
    SSP_IDLE  = 3'b001,
    SSP_FILL  = 3'b010,
    SSP_READY = 3'b100
  } ssp_state_t;
endpackage : ssp_pkg

// >>> hdl/ssp_attr_store.sv
`timescale 1ns/1ps
module ssp_attr_store #(
  parameter int SLOTS = ssp_pkg::ATTR_SLOTS
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // record writes
  input  wire logic       wrEn,
  input  wire logic [8:0] wrAddr,
  input  wire logic [7:0] wrData,
  output logic            wrRejected,
  // page reads
  input  wire logic [8:0] rdAddr,
  output logic [7:0]      rdData
);
  import ssp_pkg::*;
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  localparam logic [8:0] AREA = 9'(SLOTS * REC_BYTES);

  logic [7:0]       mem [SLOTS*REC_BYTES];
  logic [SLOTS-1:0] slotUsed;
  logic             inRange;
  logic             idWr;
  logic             idBad;
  logic [7:0]       initVal;

  function automatic logic [4:0] slotOf(input logic [8:0] a);
    slotOf = 5'(a / 9'(REC_BYTES));
  endfunction : slotOf

  function automatic logic knownId(input logic [7:0] id);
    knownId = 1'b0;
    for (int i = 0; i < ID_COUNT; i++)
      if (ATTR_IDS[i] == id)
        knownId = 1'b1;
  endfunction : knownId

  assign inRange = wrAddr < AREA;
  assign idWr    = wrEn && inRange
                   && 4'(wrAddr - 9'(slotOf(wrAddr) * 9'(REC_BYTES)))
                      == REC_ID;
  // non-zero identifiers outside the fixed table are refused
  assign idBad   = idWr && wrData != 8'h00 && !knownId(wrData); // RL6
  // crc error count starts higher than the others
  assign initVal = (wrData == ATTR_ID_CRC) ? VAL_CRC : VAL_INIT; // RL5

  always_ff @(posedge ref_clk)
  begin
    if (wrEn && inRange && !idBad)
      mem[wrAddr] <= wrData;
    if (idWr && wrData != 8'h00 && !idBad)
    begin
      mem[9'(wrAddr + {5'h00, REC_VAL})]   <= initVal; // RL5
      mem[9'(wrAddr + {5'h00, REC_WORST})] <= initVal;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slotUsed   <= '0;
      wrRejected <= 1'b0;
    end
    else
    begin
      wrRejected <= idBad;
      // a zero identifier frees the slot
      if (idWr && !idBad)
        slotUsed[slotOf(wrAddr)] <= (wrData != 8'h00); // RL4
    end
  end

  // unused slots read as all zero, so stale bytes never leak out
  assign rdData = (rdAddr < AREA && slotUsed[slotOf(rdAddr)])
                  ? mem[rdAddr] : 8'h00; // RL4

  AST_UNUSED_ZERO: assert property ( // RL4
    rdAddr < AREA && !slotUsed[slotOf(rdAddr)] |-> rdData == 8'h00)
    else $error("unused slot read non-zero");

  AST_CRC_INIT: assert property ( // RL5
    idWr && wrData == ATTR_ID_CRC |=>
      mem[9'($past(wrAddr) + 9'h003)] == VAL_CRC)
    else $error("crc attribute not preset to c8h");

  AST_UNKNOWN_ID: assert property ( // RL6
    idWr && (wrData == 8'h06 || wrData == 8'h0b) |=> wrRejected)
    else $error("unassigned identifier accepted");
endmodule : ssp_attr_store

// >>> dv/ssp_host_model.sv
`timescale 1ns/1ps
module ssp_host_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // page transfer
  input  wire logic       dataReq,
  input  wire logic [7:0] rdData,
  input  wire logic       slow,
  output logic            rdStrobe,
  output logic [7:0]      page [512],
  output int              pageCount
);
  import ssp_pkg::*;
  initial
  begin
    rdStrobe  = 1'b0;
    pageCount = 0;
    // no status polls of its own, only full page pulls
    forever
    begin
      @(posedge ref_clk);
      if (rst_n === 1'b1 && dataReq === 1'b1)
      begin
        for (int i = 0; i < PAGE_BYTES; i++)
        begin
          @(posedge ref_clk);
          #2 rdStrobe = 1'b1;
          @(posedge ref_clk);
          // byte lands one cycle after its strobe
          #1 page[i] = rdData;
          #1 rdStrobe = 1'b0;
          if (slow)
            repeat (3) @(posedge ref_clk);
        end
        pageCount++;
      end
    end
  end
endmodule : ssp_host_model

// >>> dv/ssp_page_builder_tb.sv
`timescale 1ns/1ps
module ssp_page_builder_tb;
  import ssp_pkg::*;
  localparam logic [7:0] PS = 8'h03;
  localparam logic [7:0] PE = 8'h21;
  logic        ref_clk, rst_n, pageReq, rdStrobe, hostCmd, hostReset;
  logic        busy, dataReq, intReq, attrWrEn, attrWrRejected, rej, slow;
  logic        autoCollEn, abortOnCmd, collStart, collResume, collDone;
  logic        collFatal, stStart, stPass, stFail, stFatal, stAbortCmd;
  logic        testExtend, testAbort;
  logic [1:0]  stFailElem;
  logic [3:0]  stPct;
  logic [7:0]  rdData, attrWrData, stFailChk;
  logic [7:0]  pg [512];
  logic [8:0]  attrWrAddr;
  logic [15:0] collTimeSec;
  int          pageCount, badCount, samplesChecked, extCount, abtCount;

  ssp_page_builder #(.POLL_SHORT(PS), .POLL_EXT(PE)) ssp_page_builder_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .pageReq(pageReq),
    .rdStrobe(rdStrobe), .hostCmd(hostCmd), .hostReset(hostReset),
    .busy(busy), .dataReq(dataReq), .intReq(intReq), .rdData(rdData),
    .attrWrEn(attrWrEn), .attrWrAddr(attrWrAddr), .attrWrData(attrWrData),
    .attrWrRejected(attrWrRejected), .autoCollEn(autoCollEn),
    .abortOnCmd(abortOnCmd), .collStart(collStart),
    .collResume(collResume), .collDone(collDone), .collFatal(collFatal),
    .collTimeSec(collTimeSec), .stStart(stStart), .stPct(stPct),
    .stPass(stPass), .stFail(stFail), .stFailElem(stFailElem),
    .stFailChk(stFailChk), .stFatal(stFatal), .stAbortCmd(stAbortCmd),
    .testExtend(testExtend), .testAbort(testAbort));

  ssp_host_model ssp_host_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .dataReq(dataReq),
    .rdData(rdData), .slow(slow), .rdStrobe(rdStrobe), .page(pg),
    .pageCount(pageCount));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (testExtend === 1'b1)
      extCount++;
    if (testAbort === 1'b1)
      abtCount++;
  end

  task finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] fold(input int lo, hi, input bit add);
    logic [7:0] a;
    a = 8'h00;
    for (int i = lo; i <= hi; i++)
      a = add ? a + pg[i] : a | pg[i];
    return a;
  endfunction : fold

  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #2 s = 1'b1;
    @(posedge ref_clk);
    #2 s = 1'b0;
  endtask : pulse

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2 attrWrEn = 1'b1;
    attrWrAddr = a;
    attrWrData = d;
    @(posedge ref_clk);
    #2 rej = attrWrRejected;
    attrWrEn = 1'b0;
  endtask : wr

  // one full page pull, with handshake timing judged on the way
  task automatic read_page();
    int n;
    int c;
    c = pageCount;
    @(posedge ref_clk);
    #2 pageReq = 1'b1;
    @(posedge ref_clk);
    #2 pageReq = 1'b0;
    chk({7'h00, busy}, 8'h01, "busy");
    n = 0;
    while (busy === 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      #2 n++;
    end
    chk(8'(n - 500), 8'h0c, "busy span");
    chk({6'h00, dataReq, intReq}, 8'h03, "ready");
    n = 0;
    while (pageCount == c && n < 4000)
    begin
      @(posedge ref_clk);
      #2 n++;
    end
    chk({7'h00, dataReq}, 8'h00, "drq end");
    chk(fold(0, 511, 1'b1), 8'h00, "sum");
    chk(fold(374, 510, 1'b0) | pg[366], 8'h00, "rsvd");
  endtask : read_page

  task t_fixed();
    read_page();
    chk(pg[0], 8'h10, "rev lo");
    chk(pg[1], 8'h00, "rev hi");
    chk(fold(2, 361, 1'b0), 8'h00, "empty slots");
    chk(pg[362], 8'h00, "coll");
    chk(pg[363], 8'h00, "test");
    chk(pg[364], 8'h34, "time lo");
    chk(pg[365], 8'h12, "time hi");
    chk(pg[367], 8'h5b, "cap");
    chk(pg[368], 8'h03, "scap lo");
    chk(pg[369], 8'h00, "scap hi");
    chk(pg[371], 8'h00, "chkpt");
    chk(pg[372], PS, "poll s");
    chk(pg[373], PE, "poll e");
    $display("t_fixed done");
  endtask : t_fixed

  task t_attr();
    wr(9'h00c, ATTR_ID_CRC);
    chk({7'h00, rej}, 8'h00, "crc id");
    wr(9'h000, ATTR_ID_HOURS);
    wr(9'h018, ATTR_ID_SCAN);
    wr(9'h01b, 8'h42);
    wr(9'h15c, ATTR_ID_TEMP);
    wr(9'h024, 8'h06);
    chk({7'h00, rej}, 8'h01, "bad id");
    // beyond the attribute area: must not land on the status byte
    wr(9'h168, 8'h55);
    slow = 1'b1;
    read_page();
    slow = 1'b0;
    chk(pg[14], ATTR_ID_CRC, "id 199");
    chk(pg[17], VAL_CRC, "crc val");
    chk(pg[18], VAL_CRC, "crc worst");
    chk(pg[2], ATTR_ID_HOURS, "id 9");
    chk(pg[5], 8'h64, "init val");
    chk(pg[29], 8'h42, "field");
    chk(pg[350], ATTR_ID_TEMP, "slot 29");
    chk(pg[38], 8'h00, "dropped");
    chk(pg[362], 8'h00, "refused");
    wr(9'h00c, 8'h00);
    read_page();
    chk(fold(14, 25, 1'b0), 8'h00, "freed");
    $display("t_attr done");
  endtask : t_attr

  task automatic coll_case(input logic ae, ab, input logic [3:0] ev,
                           input logic [7:0] exp);
    autoCollEn = ae;
    abortOnCmd = ab;
    pulse(collStart);
    if (ev[0])
      pulse(hostCmd);
    if (ev[1])
      pulse(collResume);
    if (ev[2])
      pulse(collDone);
    if (ev[3])
      pulse(collFatal);
    read_page();
    chk(pg[362], exp, "coll code");
    chk(pg[367], 8'h5b | {5'h00, ab, 2'h0}, "cap bit2");
  endtask : coll_case

  task t_coll();
    coll_case(1'b1, 1'b0, 4'h1, 8'h84);
    coll_case(1'b1, 1'b0, 4'h6, 8'h82);
    coll_case(1'b0, 1'b0, 4'h7, 8'h02);
    coll_case(1'b1, 1'b1, 4'h0, 8'h85);
    coll_case(1'b0, 1'b1, 4'h1, 8'h05);
    coll_case(1'b0, 1'b0, 4'h8, 8'h06);
    autoCollEn = 1'b0;
    abortOnCmd = 1'b0;
    $display("t_coll done");
  endtask : t_coll

  task t_run();
    int e;
    stPct = 4'h9;
    pulse(stStart);
    e = extCount;
    read_page();
    chk(pg[363], 8'hf9, "running");
    chk(8'(extCount - e), 8'h01, "extend");
    stPct = 4'h5;
    read_page();
    chk(pg[363], 8'hf5, "pct");
    stPct = 4'hc;
    read_page();
    chk(pg[363], 8'hf5, "pct held");
    pulse(stPass);
    read_page();
    chk(pg[363], 8'h00, "pass");
    stPct = 4'h9;
    $display("t_run done");
  endtask : t_run

  task automatic st_case(input logic [2:0] ev, input logic [1:0] el,
                         input logic [3:0] exp);
    int a;
    a = abtCount;
    stFailElem = el;
    stFailChk = {3'h5, ev, el};
    pulse(stStart);
    case (ev)
      3'h0: pulse(hostReset);
      3'h1: pulse(stAbortCmd);
      3'h2: pulse(stFatal);
      3'h3: pulse(stFail);
      default: abortOnCmd = 1'b1;
    endcase
    read_page();
    abortOnCmd = 1'b0;
    chk(pg[363] & 8'hf0, {exp, 4'h0}, "result");
    if (ev == 3'h2 || ev == 3'h3)
      chk(pg[371], stFailChk, "chkpt");
    if (ev == 3'h5)
      chk(8'(abtCount - a), 8'h01, "abort pulse");
  endtask : st_case

  task t_st();
    st_case(3'h0, 2'h0, 4'h2);
    st_case(3'h1, 2'h0, 4'h1);
    st_case(3'h5, 2'h0, 4'h1);
    st_case(3'h2, 2'h0, 4'h3);
    for (int e = 0; e < 4; e++)
      st_case(3'h3, 2'(e), 4'(4 + e));
    $display("t_st done");
  endtask : t_st

  initial
  begin
    {rst_n, pageReq, hostCmd, hostReset, attrWrEn, slow, rej} = '0;
    {autoCollEn, abortOnCmd, collStart, collResume, collDone} = '0;
    {collFatal, stStart, stPass, stFail, stFatal, stAbortCmd} = '0;
    {attrWrAddr, attrWrData, stFailElem, stFailChk} = '0;
    stPct = 4'h9;
    collTimeSec = 16'h1234;
    {badCount, samplesChecked, extCount, abtCount} = '0;
    repeat (10) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    t_fixed();
    t_attr();
    t_coll();
    t_run();
    t_st();
    finish_test();
  end

  // about 34k cycles expected; the 80k-cycle limit means a hang
  initial
  begin
    #2000000;
    badCount++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end
endmodule : ssp_page_builder_tb
